// ==== tb/psr_mdio_station.sv ====
// Management station model: clocks frames on mdc and resolves the shared data wire.
// Assumes the wire has a pull-up; mdc stands low between frames.
`timescale 1ns/1ns
module psr_mdio_station #(
  parameter int PRE = 4
) (
  output logic      mdc,
  output wire logic mdioIn,
  input  wire logic mdioOut,
  input  wire logic mdioOe_n
);
  logic stDrive;
  logic stBit;

  // Block wins when enabled, else the station, else the pull-up
  assign mdioIn = !mdioOe_n ? mdioOut : (stDrive ? stBit : 1'b1);

  initial begin
    mdc = 1'b0;
    stDrive = 1'b0;
    stBit = 1'b1;
  end

  task automatic cyc(input logic drv, input logic b, output logic s);
    stDrive = drv;
    stBit = b;
    #400;
    s = mdioIn;
    mdc = 1'b1;
    #400;
    mdc = 1'b0;
  endtask

  task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic        s;
    logic [13:0] hdr;
    hdr = {2'b01, rd ? 2'b10 : 2'b01, phy, ra};
    for (int i = 0; i < PRE; i++) cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) cyc(1'b1, hdr[i], s);
    cyc(!rd, 1'b1, s);
    cyc(!rd, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      cyc(!rd, wd[i], s);
      q[i] = s;
    end
    stDrive = 1'b0;
  endtask
endmodule

// ==== tb/psr_regs_asserts.sv ====
// Checker for the PHY register pair: switch-side writes, reads and control outputs.
// Assumes it is bound to psr_phy_basic_regs; every watched signal is on clk.
`timescale 1ns/1ns
module psr_regs_asserts #(
  parameter int PREAMBLE_BITS = 32
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       swWrEn,
  input wire logic [7:0] swAddr,
  input wire logic [7:0] swWdata,
  input wire logic [7:0] swRdata,
  input wire logic [1:0] linkUp,
  input wire logic [1:0] autonegDone,
  input wire logic [1:0] farEndFault,
  input wire logic [1:0] loopbackEn,
  input wire logic [1:0] force100,
  input wire logic [1:0] autonegEnable,
  input wire logic [1:0] powerDown,
  input wire logic [1:0] autonegRestart,
  input wire logic [1:0] fullDuplex,
  input wire logic [1:0] crossoverAlgorithmSelect,
  input wire logic [1:0] straightPairForce,
  input wire logic [1:0] crossoverDisable,
  input wire logic       farEndFaultDisable,
  input wire logic [1:0] txDisable,
  input wire logic [1:0] ledDisable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  p1_ctrl_a: assert property (
    swWrEn && swAddr == 8'h1d |=> {ledDisable[0], txDisable[0], autonegRestart[0],
      farEndFaultDisable, powerDown[0], crossoverDisable[0], straightPairForce[0],
      loopbackEn[0]} == $past(swWdata))
    else $error("port 1 control byte not applied");
  p2_ctrl_a: assert property (
    swWrEn && swAddr == 8'h2d |=> {ledDisable[1], txDisable[1], autonegRestart[1],
      powerDown[1], crossoverDisable[1], straightPairForce[1], loopbackEn[1]}
      == {$past(swWdata[7:5]), $past(swWdata[3:0])})
    else $error("port 2 control byte not applied");
  p1_force_a: assert property (
    swWrEn && swAddr == 8'h1c |=> {autonegEnable[0], force100[0], fullDuplex[0]}
      == $past(swWdata[7:5]))
    else $error("port 1 force byte not applied");
  p2_force_a: assert property (
    swWrEn && swAddr == 8'h2c |=> {autonegEnable[1], force100[1], fullDuplex[1]}
      == $past(swWdata[7:5]))
    else $error("port 2 force byte not applied");
  xover_sel_a: assert property (
    swWrEn && swAddr == 8'h1f |=> crossoverAlgorithmSelect[0] == $past(swWdata[7]))
    else $error("crossover select not applied");
  fef_port1_a: assert property (
    swWrEn && swAddr == 8'h2d |=> $stable(farEndFaultDisable))
    else $error("port 2 write moved fault disable");
  status_mirror_a: assert property (
    swAddr == 8'h1e |=> swRdata == {1'b0, $past(autonegDone[0]), $past(linkUp[0]), 5'h00})
    else $error("port status byte wrong");
  fault_read_a: assert property (
    swAddr == 8'h2f |=> swRdata == {$past(crossoverAlgorithmSelect[1]), 6'h00,
      $past(farEndFault[1])})
    else $error("port 2 special byte wrong");
  unmapped_zero_a: assert property (
    swAddr == 8'h20 |=> swRdata == 8'h00)
    else $error("unmapped address read not zero");
endmodule

bind psr_phy_basic_regs psr_regs_asserts #(.PREAMBLE_BITS(PREAMBLE_BITS)) chk (.*);

// ==== tb/tb_top.sv ====
// Testbench for the PHY register pair: management frames and switch-side accesses.
// Assumes the station model and the bound checker are compiled before it.
`timescale 1ns/1ns
module tb_top;
  logic       clk, reset_n, swWrEn;
  logic [7:0] swAddr, swWdata;
  logic [1:0] linkUp, autonegDone, farEndFault;
  wire  logic       mdc, mdioIn, mdioOut, mdioOe_n, farEndFaultDisable;
  wire  logic [7:0] swRdata;
  wire  logic [1:0] loopbackEn, force100, autonegEnable, powerDown, autonegRestart;
  wire  logic [1:0] fullDuplex, crossoverAlgorithmSelect, straightPairForce;
  wire  logic [1:0] crossoverDisable, txDisable, ledDisable;
  int         mismatches, n_compared;

  psr_phy_basic_regs #(.PREAMBLE_BITS(4)) uut (.*);
  psr_mdio_station #(.PRE(4)) stn (.mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
                                   .mdioOe_n(mdioOe_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic swWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #10 swWrEn = 1'b1;
    swAddr = a;
    swWdata = d;
    @(posedge clk);
    #10 swWrEn = 1'b0;
  endtask

  task automatic swChk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #10 swAddr = a;
    @(posedge clk);
    #10 check("swRdata", {8'h00, swRdata}, {8'h00, e});
  endtask

  task automatic mdChk(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] d;
    stn.frame(1'b1, phy, ra, 16'h0000, d);
    check("mdio read", d, e);
  endtask

  task automatic mdWr(input logic [4:0] phy, input logic [15:0] d);
    logic [15:0] unused;
    stn.frame(1'b0, phy, 5'h00, d, unused);
    repeat (10) @(posedge clk);
  endtask

  task automatic test_reset;
    logic [15:0] v;
    mdChk(5'h01, 5'h00, 16'h1020);
    mdChk(5'h02, 5'h00, 16'h1020);
    mdChk(5'h01, 5'h01, 16'h7808);
    check("autonegEnable", 16'(autonegEnable), 16'h0003);
    v = {force100, powerDown, autonegRestart, fullDuplex,
         straightPairForce, crossoverDisable, txDisable, ledDisable};
    check("reset controls", v, 16'h0000);
    v = 16'({loopbackEn, farEndFaultDisable, crossoverAlgorithmSelect});
    check("reset loop and xover", v, 16'h0003);
    swChk(8'h1c, 8'h80);
    $display("test_reset done");
  endtask

  task automatic test_md_write;
    logic [15:0] v;
    mdWr(5'h01, 16'hffff);
    mdChk(5'h01, 5'h00, 16'h7b3f);
    check("loopbackEn", 16'(loopbackEn), 16'h0001);
    v = 16'({loopbackEn[0], force100[0], autonegEnable[0], powerDown[0], autonegRestart[0],
             fullDuplex[0], crossoverAlgorithmSelect[0], straightPairForce[0],
             crossoverDisable[0], farEndFaultDisable, txDisable[0], ledDisable[0]});
    check("port 1 controls", v, 16'h0fff);
    swChk(8'h1d, 8'hff);
    mdChk(5'h02, 5'h00, 16'h1020);
    mdWr(5'h02, 16'hffff);
    mdChk(5'h02, 5'h00, 16'h7b3b);
    check("loopbackEn", 16'(loopbackEn), 16'h0003);
    v = 16'({loopbackEn[1], force100[1], autonegEnable[1], powerDown[1], autonegRestart[1],
             fullDuplex[1], crossoverAlgorithmSelect[1], straightPairForce[1],
             crossoverDisable[1], txDisable[1], ledDisable[1]});
    check("port 2 controls", v, 16'h07ff);
    mdWr(5'h01, 16'h0000);
    mdWr(5'h02, 16'h0000);
    mdChk(5'h01, 5'h01, 16'h7800);
    check("autonegEnable", 16'(autonegEnable), 16'h0000);
    $display("test_md_write done");
  endtask

  task automatic test_sw_alias;
    swWr(8'h1c, 8'he0);
    swWr(8'h1d, 8'h09);
    swWr(8'h1f, 8'h00);
    swWr(8'h2c, 8'h60);
    swWr(8'h2d, 8'h01);
    swWr(8'h20, 8'hff);
    mdChk(5'h01, 5'h00, 16'h7900);
    mdChk(5'h02, 5'h00, 16'h6100);
    check("powerDown", 16'(powerDown), 16'h0001);
    swChk(8'h20, 8'h00);
    $display("test_sw_alias done");
  endtask

  task automatic test_status;
    @(posedge clk);
    #10 linkUp = 2'b10;
    autonegDone = 2'b01;
    farEndFault = 2'b11;
    mdChk(5'h01, 5'h01, 16'h7838);
    mdChk(5'h02, 5'h01, 16'h7814);
    swChk(8'h1e, 8'h40);
    swChk(8'h2f, 8'h01);
    swWr(8'h1d, 8'h19);
    mdChk(5'h01, 5'h01, 16'h7828);
    $display("test_status done");
  endtask

  task automatic test_select;
    logic [15:0] v;
    swWr(8'h0f, 8'h28);
    swChk(8'h0f, 8'h28);
    mdWr(5'h01, 16'hffff);
    mdChk(5'h05, 5'h00, 16'h7904);
    mdChk(5'h06, 5'h00, 16'h6100);
    stn.frame(1'b0, 5'h05, 5'h01, 16'h0000, v);
    mdChk(5'h05, 5'h00, 16'h7904);
    mdChk(5'h01, 5'h00, 16'hffff);
    mdChk(5'h05, 5'h02, 16'h0000);
    swWr(8'h0f, 8'h08);
    $display("test_select done");
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    swWrEn = 1'b0;
    swAddr = 8'h00;
    swWdata = 8'h00;
    linkUp = 2'b00;
    autonegDone = 2'b00;
    farEndFault = 2'b00;
    mismatches = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    #10 reset_n = 1'b1;
    repeat (2) @(posedge clk);
    test_reset;
    test_md_write;
    test_sw_alias;
    test_status;
    test_select;
    wrap_up;
  end

  // About four times the expected run
  initial begin
    #3000000;
    mismatches++;
    wrap_up;
  end
endmodule

// ==== verilog/psr_params.svh ====
// Offsets, field positions, reset values and timing counts for the PHY register pair.
// Assumes it is included by bare name before any module that uses the macros.
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// Management frame fields
`define PSR_PREAMBLE_BITS   32
`define PSR_OP_READ         2'b10
`define PSR_OP_WRITE        2'b01
`define PSR_START_CODE      2'b01
`define PSR_REG_CONTROL     5'h00
`define PSR_REG_STATUS      5'h01
`define PSR_PHY_BASE_RST    5'h01

// Control word bit positions
`define PSR_CTL_LOOPBACK    14
`define PSR_CTL_FORCE100    13
`define PSR_CTL_AUTONEG_ENABLE   12
`define PSR_CTL_POWER_DOWN  11
`define PSR_CTL_AN_RESTART  9
`define PSR_CTL_FULL_DUPLEX 8
`define PSR_CTL_XOVER_SEL   5
`define PSR_CTL_STRAIGHT    4
`define PSR_CTL_XOVER_DIS   3
`define PSR_CTL_FEF_DIS     2
`define PSR_CTL_TX_DIS      1
`define PSR_CTL_LED_DIS     0

// Status word bit positions
`define PSR_STA_CAP_LSB     11
`define PSR_STA_CAP_MSB     14
`define PSR_STA_AN_DONE     5
`define PSR_STA_FAR_FAULT   4
`define PSR_STA_AN_ABLE     3
`define PSR_STA_LINK        2

// Switch register offsets: global select base, then port 1 (port 2 adds the stride)
`define PSR_SW_GLOBAL13     8'h0f
`define PSR_SW_P1_FORCE     8'h1c
`define PSR_SW_P1_CTRL      8'h1d
`define PSR_SW_P1_STAT      8'h1e
`define PSR_SW_P1_SPEC      8'h1f
`define PSR_SW_PORT_STRIDE  8'h10

// Switch register bit positions
`define PSR_SW_AN_EN_BIT    7
`define PSR_SW_F100_BIT     6
`define PSR_SW_FDX_BIT      5
`define PSR_SW_LED_BIT      7
`define PSR_SW_TX_BIT       6
`define PSR_SW_RST_BIT      5
`define PSR_SW_FEF_BIT      4
`define PSR_SW_PD_BIT       3
`define PSR_SW_MDIX_BIT     2
`define PSR_SW_MDI_BIT      1
`define PSR_SW_LB_BIT       0
`define PSR_SW_XSEL_BIT     7
`define PSR_SW_FAULT_BIT    0
`define PSR_SW_DONE_BIT     6
`define PSR_SW_LINK_BIT     5
`define PSR_SW_BASE_LSB     3

// Reset values of stored control bits
`define PSR_RST_AUTONEG_ENABLE   1'b1
`define PSR_RST_XOVER_SEL   1'b1

`endif

// ==== verilog/psr_phy_basic_regs.sv ====
// PHY basic control and status registers for both PHYs, reached over management serial pins.
// Assumes mdc/mdio come from outside the clock domain; the switch register port and
// the PHY status inputs are on clk.
//
// Contract
// - PHY 1 answers at select code 1, PHY 2 at 2; both reprogrammable globally.
// - Control bit 14 enables far-end loopback; resets to zero.
// - Port 1 loopback wraps port 2 traffic; mirrors switch register 29 bit 0.
// - Port 2 loopback wraps port 1 traffic; mirrors switch register 45 bit 0.
// - Control bit 13 selects forced speed, one is 100 Mbps; resets zero.
// - Control bit 12 enables auto-negotiation; resets to one.
// - Control bit 11 powers the PHY down; resets to zero.
// - Control bit 9 restarts auto-negotiation; mirrors port control bit 5.
// - Control bit 8 selects forced duplex, one is full; resets zero.
// - Control bit 5 chooses crossover algorithm variant; resets to one.
// - Control bit 4 forces transmit on the receive pair.
// - Control bit 3 disables automatic crossover; resets to zero.
// - Control bit 2 disables far-end fault detection; only port 1 register 29.
// - Control bit 1 disables the transmitter; resets to zero.
// - Control bit 0 switches off the port LED; resets to zero.
// - Writable control bits alias switch registers; either path sees the other.
// - Status bits 14 to 11 always read one.
// - Status bit 15 always reads zero.
// - Status bit 0 always reads zero.
// - Status bit 5 shows auto-negotiation done, from port status bit 6.
// - Status bit 4 shows a detected far-end fault.
// - Status bit 3 tracks the auto-negotiation enable; resets one.
// - Status bit 2 shows link up, from port status bit 5.
`timescale 1ns/1ns
`include "psr_params.svh"

module psr_phy_basic_regs #(
  parameter int PREAMBLE_BITS = `PSR_PREAMBLE_BITS
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       mdc,
  input  wire logic       mdioIn,
  output logic            mdioOut,
  output logic            mdioOe_n,
  input  wire logic       swWrEn,
  input  wire logic [7:0] swAddr,
  input  wire logic [7:0] swWdata,
  output logic      [7:0] swRdata,
  input  wire logic [1:0] linkUp,
  input  wire logic [1:0] autonegDone,
  input  wire logic [1:0] farEndFault,
  output logic      [1:0] loopbackEn,
  output logic      [1:0] force100,
  output logic      [1:0] autonegEnable,
  output logic      [1:0] powerDown,
  output logic      [1:0] autonegRestart,
  output logic      [1:0] fullDuplex,
  output logic      [1:0] crossoverAlgorithmSelect,
  output logic      [1:0] straightPairForce,
  output logic      [1:0] crossoverDisable,
  output logic            farEndFaultDisable,
  output logic      [1:0] txDisable,
  output logic      [1:0] ledDisable
);
  import psr_pkg::*;
  if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > 63) begin : g_bad_preamble
    $error("PREAMBLE_BITS must lie in 1..63");
  end
  localparam logic [5:0] PRE_CNT = 6'(PREAMBLE_BITS);
  // Stored control bits, one per port; the far-end fault disable has a single bit, for port 1 only
  logic [1:0] lb_r, f100_r, anEn_r, pd_r, anRst_r, fdx_r;
  logic [1:0] xsel_r, mdi_r, mdixDis_r, txDis_r, ledDis_r;
  logic       fefDis_r;
  logic [4:0] phyBase_r;
  logic [7:0] swRdata_r;
  // Pin synchronisers and filtered levels
  logic [2:0] mdcSync_r, mdioSync_r;
  logic       mdcF_r, mdioF_r;
  logic       mdcRise;
  // Frame engine
  psr_frame_e state_r;
  logic [5:0]  preCnt_r;
  logic [3:0]  hdrCnt_r;
  logic [12:0] hdr_r;
  logic [3:0]  bitCnt_r;
  logic        opRead_r, hit_r, port_r;
  logic [4:0]  regIdx_r;
  psr_word_t   shift_r;
  logic        mdWrite_r;
  logic        mdPort_r;
  psr_word_t   mdWdata_r;
  logic        mdioOut_r, mdioOeN_r;
  psr_word_t ctrlWord [2];
  psr_word_t statWord [2];
  logic [13:0] hdrFull;
  logic [4:0]  phy1Code, phy2Code;
  logic        hdrHit, hdrPort;
  psr_word_t   readWord;
  function automatic logic [7:0] portAddr(input logic pSel, input logic [7:0] a);
    portAddr = a + (pSel ? `PSR_SW_PORT_STRIDE : 8'h00);
  endfunction
  // Three-stage synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mdcSync_r  <= 3'h0;
      mdioSync_r <= 3'h7;
    end else begin
      mdcSync_r  <= {mdcSync_r[1:0], mdc};
      mdioSync_r <= {mdioSync_r[1:0], mdioIn};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mdcF_r  <= 1'b0;
      mdioF_r <= 1'b1;
    end else begin
      if (mdcSync_r[1] == mdcSync_r[2]) begin
        mdcF_r <= mdcSync_r[2];
      end
      if (mdioSync_r[1] == mdioSync_r[2]) begin
        mdioF_r <= mdioSync_r[2];
      end
    end
  end
  assign mdcRise = (mdcSync_r[1] == mdcSync_r[2]) && mdcSync_r[2] && !mdcF_r;
  // Register words as seen by the management station
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      ctrlWord[p] = 16'h0000;
      ctrlWord[p][`PSR_CTL_LOOPBACK]    = lb_r[p];
      ctrlWord[p][`PSR_CTL_FORCE100]    = f100_r[p];
      ctrlWord[p][`PSR_CTL_AUTONEG_ENABLE]   = anEn_r[p];
      ctrlWord[p][`PSR_CTL_POWER_DOWN]  = pd_r[p];
      ctrlWord[p][`PSR_CTL_AN_RESTART]  = anRst_r[p];
      ctrlWord[p][`PSR_CTL_FULL_DUPLEX] = fdx_r[p];
      ctrlWord[p][`PSR_CTL_XOVER_SEL]   = xsel_r[p];
      ctrlWord[p][`PSR_CTL_STRAIGHT]    = mdi_r[p];
      ctrlWord[p][`PSR_CTL_XOVER_DIS]   = mdixDis_r[p];
      ctrlWord[p][`PSR_CTL_FEF_DIS]     = (p == 0) ? fefDis_r : 1'b0;
      ctrlWord[p][`PSR_CTL_TX_DIS]      = txDis_r[p];
      ctrlWord[p][`PSR_CTL_LED_DIS]     = ledDis_r[p];
      statWord[p] = 16'h0000;
      statWord[p][`PSR_STA_CAP_MSB:`PSR_STA_CAP_LSB] = 4'hf;
      statWord[p][`PSR_STA_AN_DONE]   = autonegDone[p];
      statWord[p][`PSR_STA_FAR_FAULT] = farEndFault[p] && !((p == 0) && fefDis_r);
      statWord[p][`PSR_STA_AN_ABLE]   = anEn_r[p];
      statWord[p][`PSR_STA_LINK]      = linkUp[p];
    end
  end
  // Header decode; PHY 2 answers one above the programmable base
  assign hdrFull  = {hdr_r, mdioF_r};
  assign phy1Code = phyBase_r;
  assign phy2Code = phyBase_r + 5'h01;
  assign hdrHit   = (hdrFull[9:5] == phy1Code) || (hdrFull[9:5] == phy2Code);
  assign hdrPort  = (hdrFull[9:5] == phy2Code);
  always_comb begin
    readWord = 16'h0000;
    if (regIdx_r == `PSR_REG_CONTROL) begin
      readWord = ctrlWord[port_r];
    end else if (regIdx_r == `PSR_REG_STATUS) begin
      readWord = statWord[port_r];
    end
  end

  // Management frame engine, advanced on each filtered mdc rising edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= FS_PRE;
      preCnt_r  <= 6'h00;
      hdrCnt_r  <= 4'h0;
      hdr_r     <= 13'h0000;
      bitCnt_r  <= 4'h0;
      opRead_r  <= 1'b0;
      hit_r     <= 1'b0;
      port_r    <= 1'b0;
      regIdx_r  <= 5'h00;
      shift_r   <= 16'h0000;
      mdWrite_r <= 1'b0;
      mdPort_r  <= 1'b0;
      mdWdata_r <= 16'h0000;
      mdioOut_r <= 1'b1;
      mdioOeN_r <= 1'b1;
    end else begin
      mdWrite_r <= 1'b0;
      if (mdcRise) begin
        unique case (state_r)
          FS_PRE: begin
            if (mdioF_r) begin
              if (preCnt_r < PRE_CNT) begin
                preCnt_r <= preCnt_r + 6'h01;
              end
            end else if (preCnt_r >= PRE_CNT) begin
              state_r  <= FS_HDR;
              hdr_r    <= 13'h0000;
              hdrCnt_r <= 4'h1;
            end else begin
              preCnt_r <= 6'h00;
            end
          end
          FS_HDR: begin
            hdr_r    <= hdrFull[12:0];
            hdrCnt_r <= hdrCnt_r + 4'h1;
            if (hdrCnt_r == 4'hd) begin
              preCnt_r <= 6'h00;
              bitCnt_r <= 4'h0;
              opRead_r <= (hdrFull[11:10] == `PSR_OP_READ);
              hit_r    <= hdrHit;
              port_r   <= hdrPort;
              regIdx_r <= hdrFull[4:0];
              if (hdrFull[13:12] == `PSR_START_CODE &&
                  (hdrFull[11:10] == `PSR_OP_READ || hdrFull[11:10] == `PSR_OP_WRITE)) begin
                state_r <= FS_TA;
              end else begin
                state_r <= FS_PRE;
              end
            end
          end
          FS_TA: begin
            if (bitCnt_r == 4'h0) begin
              bitCnt_r <= 4'h1;
              if (opRead_r && hit_r) begin
                mdioOut_r <= 1'b0;
                mdioOeN_r <= 1'b0;
              end
            end else begin
              bitCnt_r <= 4'h0;
              state_r  <= opRead_r ? FS_RD : FS_WR;
              if (opRead_r && hit_r) begin
                mdioOut_r <= readWord[15];
                shift_r   <= {readWord[14:0], 1'b0};
              end
            end
          end
          FS_RD: begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == 4'hf) begin
              mdioOut_r <= 1'b1;
              mdioOeN_r <= 1'b1;
              state_r   <= FS_PRE;
            end else begin
              mdioOut_r <= shift_r[15];
              shift_r   <= {shift_r[14:0], 1'b0};
            end
          end
          FS_WR: begin
            bitCnt_r <= bitCnt_r + 4'h1;
            shift_r  <= {shift_r[14:0], mdioF_r};
            if (bitCnt_r == 4'hf) begin
              state_r   <= FS_PRE;
              mdWrite_r <= hit_r && (regIdx_r == `PSR_REG_CONTROL);
              mdPort_r  <= port_r;
              mdWdata_r <= {shift_r[14:0], mdioF_r};
            end
          end
        endcase
      end
    end
  end

  // Control bits shared by both paths; a same-cycle management write wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lb_r      <= 2'b00;
      f100_r    <= 2'b00;
      anEn_r    <= {2{`PSR_RST_AUTONEG_ENABLE}};
      pd_r      <= 2'b00;
      anRst_r   <= 2'b00;
      fdx_r     <= 2'b00;
      xsel_r    <= {2{`PSR_RST_XOVER_SEL}};
      mdi_r     <= 2'b00;
      mdixDis_r <= 2'b00;
      txDis_r   <= 2'b00;
      ledDis_r  <= 2'b00;
      fefDis_r  <= 1'b0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (swWrEn && swAddr == portAddr(1'(p), `PSR_SW_P1_FORCE)) begin
          anEn_r[p] <= swWdata[`PSR_SW_AN_EN_BIT];
          f100_r[p] <= swWdata[`PSR_SW_F100_BIT];
          fdx_r[p]  <= swWdata[`PSR_SW_FDX_BIT];
        end
        if (swWrEn && swAddr == portAddr(1'(p), `PSR_SW_P1_CTRL)) begin
          ledDis_r[p]  <= swWdata[`PSR_SW_LED_BIT];
          txDis_r[p]   <= swWdata[`PSR_SW_TX_BIT];
          anRst_r[p]   <= swWdata[`PSR_SW_RST_BIT];
          pd_r[p]      <= swWdata[`PSR_SW_PD_BIT];
          mdixDis_r[p] <= swWdata[`PSR_SW_MDIX_BIT];
          mdi_r[p]     <= swWdata[`PSR_SW_MDI_BIT];
          lb_r[p]      <= swWdata[`PSR_SW_LB_BIT];
          if (p == 0) begin
            fefDis_r <= swWdata[`PSR_SW_FEF_BIT];
          end
        end
        if (swWrEn && swAddr == portAddr(1'(p), `PSR_SW_P1_SPEC)) begin
          xsel_r[p] <= swWdata[`PSR_SW_XSEL_BIT];
        end
        if (mdWrite_r && mdPort_r == 1'(p)) begin
          lb_r[p]      <= mdWdata_r[`PSR_CTL_LOOPBACK];
          f100_r[p]    <= mdWdata_r[`PSR_CTL_FORCE100];
          anEn_r[p]    <= mdWdata_r[`PSR_CTL_AUTONEG_ENABLE];
          pd_r[p]      <= mdWdata_r[`PSR_CTL_POWER_DOWN];
          anRst_r[p]   <= mdWdata_r[`PSR_CTL_AN_RESTART];
          fdx_r[p]     <= mdWdata_r[`PSR_CTL_FULL_DUPLEX];
          xsel_r[p]    <= mdWdata_r[`PSR_CTL_XOVER_SEL];
          mdi_r[p]     <= mdWdata_r[`PSR_CTL_STRAIGHT];
          mdixDis_r[p] <= mdWdata_r[`PSR_CTL_XOVER_DIS];
          txDis_r[p]   <= mdWdata_r[`PSR_CTL_TX_DIS];
          ledDis_r[p]  <= mdWdata_r[`PSR_CTL_LED_DIS];
          if (p == 0) begin
            fefDis_r <= mdWdata_r[`PSR_CTL_FEF_DIS];
          end
        end
      end
    end
  end

  // Global select code base
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phyBase_r <= `PSR_PHY_BASE_RST;
    end else if (swWrEn && swAddr == `PSR_SW_GLOBAL13) begin
      phyBase_r <= swWdata[`PSR_SW_BASE_LSB +: 5];
    end
  end

  // Switch-side read data, registered every cycle from the presented address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      swRdata_r <= 8'h00;
    end else begin
      swRdata_r <= 8'h00;
      if (swAddr == `PSR_SW_GLOBAL13) begin
        swRdata_r <= {phyBase_r, 3'h0};
      end
      for (int p = 0; p < 2; p++) begin
        if (swAddr == portAddr(1'(p), `PSR_SW_P1_FORCE)) begin
          swRdata_r <= {anEn_r[p], f100_r[p], fdx_r[p], 5'h00};
        end
        if (swAddr == portAddr(1'(p), `PSR_SW_P1_CTRL)) begin
          swRdata_r <= {ledDis_r[p], txDis_r[p], anRst_r[p], (p == 0) && fefDis_r,
                        pd_r[p], mdixDis_r[p], mdi_r[p], lb_r[p]};
        end
        if (swAddr == portAddr(1'(p), `PSR_SW_P1_STAT)) begin
          swRdata_r <= {1'b0, autonegDone[p], linkUp[p], 5'h00};
        end
        if (swAddr == portAddr(1'(p), `PSR_SW_P1_SPEC)) begin
          swRdata_r <= {xsel_r[p], 6'h00, farEndFault[p]};
        end
      end
    end
  end

  assign swRdata                  = swRdata_r;
  assign mdioOut                  = mdioOut_r;
  assign mdioOe_n                 = mdioOeN_r;
  assign loopbackEn               = lb_r;
  assign force100                 = f100_r;
  assign autonegEnable            = anEn_r;
  assign powerDown                = pd_r;
  assign autonegRestart           = anRst_r;
  assign fullDuplex               = fdx_r;
  assign crossoverAlgorithmSelect = xsel_r;
  assign straightPairForce        = mdi_r;
  assign crossoverDisable         = mdixDis_r;
  assign farEndFaultDisable       = fefDis_r;
  assign txDisable                = txDis_r;
  assign ledDisable               = ledDis_r;

endmodule

// ==== verilog/psr_pkg.sv ====
// Types for the PHY basic control/status register pair.
// Assumes nothing beyond a SystemVerilog compiler.
package psr_pkg;
  typedef enum logic [2:0] {
    FS_PRE,
    FS_HDR,
    FS_TA,
    FS_RD,
    FS_WR
  } psr_frame_e;

  typedef logic [15:0] psr_word_t;
endpackage
